// ### rtl/clbcd_decoder.sv
// Purpose: Sorts local bus cycles by kind and terminates those it owns.
// Assumes: Control strobe pins are asynchronous to clk and pass a three-stage filter.
// Notes:   DRAM and ISA engines are outside; they report done by pulses.
//
// Behaviour
// - Skip cycles claimed by another local slave.
// - Burst DRAM cycles end with burst ready.
// - DRAM timing comes from DRAM control registers.
// - Alternate master cycles treated like processor cycles.
// - Register access echoed at 16-bit ISA timing.
// - Byte access to 16-bit registers terminates.
// - ISA memory: not DRAM, unclaimed, below limit or A31 set without boot ROM enable.
// - ISA I/O: unclaimed, not special, not register.
// - ISA cycles end with ready.
// - Ready returned for every halt or special cycle.
// - Halt response is selectable.
// - Second halt option also raises management interrupt.
// - Shutdown holds resets for seventeen clocks (SHUT_CLKS plus one).
`timescale 1ns/1ps
module clbcd_decoder
    import clbcd_pkg::*;
#(
    parameter int          SHUT_CLKS = SHUT_MIN_CLKS
)(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ads_n,
    input  wire logic [31:2] addr,
    input  wire logic [3:0]  be_n,
    input  wire logic        m_io_n,
    input  wire logic        d_c_n,
    input  wire logic        w_r_n,
    input  wire logic        blast_n,
    input  wire logic        local_slave_claim_n,
    input  wire logic        boot_rom_chip_enable,
    input  wire logic        dram_hit,
    input  wire logic        reg_hit,
    input  wire logic [1:0]  halt_option,
    input  wire logic        dram_xfer_done,
    input  wire logic        dram_last_done,
    input  wire logic        isa_done,
    output logic             rdy_n_o,
    output logic             rdy_n_oe,
    output logic             brdy_n_o,
    output logic             brdy_n_oe,
    output logic             dram_start,
    output logic             isa_mem_start,
    output logic             isa_io_start,
    output logic             isa_16bit_io,
    output logic             smi_event,
    output logic             processor_reset_out,
    output logic             isa_reset_out
);

    // Three-stage filters on the control pins; a change counts only when
    // stages two and three agree, so stage one is never decoded.
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    assign pin_raw = {ads_n, local_slave_claim_n, blast_n, boot_rom_chip_enable};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_comb
            begin
                flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            // Idle level of the strobes, so no cycle is seen while the
            // stages refill after reset.
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            flt_q <= '1;
        end
        else
        begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    logic ads_f, claim_n_f, blast_f_n, rom_ce_f;
    assign ads_f     = ~flt_q[3];
    assign claim_n_f = flt_q[2];
    assign blast_f_n = flt_q[1];
    assign rom_ce_f  = flt_q[0];

    // Kind decode from address, cycle definition and claim; no processor
    // versus alternate master distinction exists at all.
    // Address and cycle definition pins skip the filter on purpose: the
    // master holds them from the strobe to termination, and they are first
    // looked at five clocks after the strobe, long after they settled.
    logic [2:0]  cdef;
    logic [31:0] full_addr;
    logic        is_special, is_io, isa_mem_ok, isa_io_ok, is_shutdown, is_halt;
    clbcd_kind_t kind_c;

    assign cdef      = {m_io_n, d_c_n, w_r_n};
    assign full_addr = {addr, 2'b00};
    assign is_special = (cdef == CDEF_SPECIAL);
    assign is_io      = (cdef == CDEF_IO_RD) || (cdef == CDEF_IO_WR);
    assign is_shutdown = is_special && (be_n == BE_SHUTDOWN) && !addr[RAW_MSB];
    assign is_halt     = is_special && (be_n == BE_HALT) && !addr[RAW_MSB];

    assign isa_mem_ok = m_io_n && d_c_n && !dram_hit && claim_n_f &&
                        ((full_addr < ISA_LIMIT) || (addr[A31_BIT] && !rom_ce_f));
    assign isa_io_ok  = is_io && claim_n_f && d_c_n && !reg_hit;

    always_comb
    begin
        // A claim hides everything, then special cycles, then register hits
        // ahead of DRAM, so each cycle is given one kind only.
        // Interrupt acknowledge falls through to no kind and is not answered.
        kind_c = CLBCD_K_NONE;
        if (!claim_n_f)
            kind_c = CLBCD_K_NONE;
        else if (is_special)
            kind_c = CLBCD_K_SPECIAL;
        else if (is_io && reg_hit)
            kind_c = CLBCD_K_REG;
        else if (m_io_n && d_c_n && dram_hit)
            kind_c = CLBCD_K_DRAM;
        else if (isa_mem_ok || isa_io_ok)
            kind_c = CLBCD_K_ISA;
    end

    // Cycle sequencer.
    clbcd_state_t st_q, st_d;
    clbcd_kind_t  kind_q, kind_d;
    logic         rdy_q, rdy_d, brdy_q, brdy_d;
    logic         dst_q, dst_d, mst_q, mst_d, ist_q, ist_d, i16_q, i16_d;
    logic         smi_q, smi_d, shut_q, shut_d;
    logic [SHUT_CNT_W-1:0] rcnt_q, rcnt_d;
    logic         rst_q, rst_d;

    always_comb
    begin
        st_d    = st_q;
        kind_d  = kind_q;
        rdy_d   = 1'b0;
        brdy_d  = 1'b0;
        dst_d   = 1'b0;
        mst_d   = 1'b0;
        ist_d   = 1'b0;
        i16_d   = i16_q;
        smi_d   = 1'b0;
        shut_d  = shut_q;
        case (st_q)
            CLBCD_IDLE:
            begin
                if (ads_f)
                    st_d = CLBCD_DECODE;
            end
            CLBCD_DECODE:
            begin
                // Kind is latched before any termination is driven.
                kind_d  = kind_c;
                shut_d  = is_shutdown;
                i16_d   = 1'b0;
                case (kind_c)
                    CLBCD_K_NONE:
                        st_d = CLBCD_END;
                    CLBCD_K_DRAM:
                    begin
                        dst_d = 1'b1;
                        st_d  = CLBCD_WAIT;
                    end
                    CLBCD_K_REG:
                    begin
                        ist_d = 1'b1;
                        i16_d = 1'b1;
                        st_d  = CLBCD_WAIT;
                    end
                    CLBCD_K_ISA:
                    begin
                        mst_d = m_io_n;
                        ist_d = !m_io_n;
                        st_d  = CLBCD_WAIT;
                    end
                    default:
                    begin
                        // Only the interrupt option acts here; every other
                        // selection answers with ready alone from this block.
                        smi_d = is_halt && (halt_option == HALT_RDY_SMI);
                        st_d  = CLBCD_TERM;
                    end
                endcase
            end
            CLBCD_WAIT:
            begin
                if (kind_q == CLBCD_K_DRAM)
                begin
                    if (dram_xfer_done)
                    begin
                        brdy_d  = 1'b1;
                        // A master may cut a burst short with its last pin,
                        // which the engine cannot foresee, so either ends it.
                        if (dram_last_done || !blast_f_n)
                            st_d = CLBCD_END;
                    end
                end
                else if (isa_done)
                    st_d = CLBCD_TERM;
            end
            CLBCD_TERM:
            begin
                rdy_d = 1'b1;
                st_d  = CLBCD_END;
            end
            default:
            begin
                // Wait for the pin filter to drop the old strobe first.
                if (!ads_f)
                    st_d = CLBCD_IDLE;
            end
        endcase
    end

    // Shutdown reset stretcher; counts from the termination onward.
    // The count loads on the ready clock and the outputs fall one clock after
    // it runs out, so they stand one clock beyond SHUT_CLKS as a margin.
    always_comb
    begin
        rcnt_d = rcnt_q;
        rst_d  = rst_q;
        if (st_q == CLBCD_TERM && shut_q)
        begin
            rst_d  = 1'b1;
            rcnt_d = SHUT_CNT_W'(SHUT_CLKS);
        end
        else if (rcnt_q != '0)
            rcnt_d = rcnt_q - 1'b1;
        else
            rst_d = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_q    <= CLBCD_IDLE;
            kind_q  <= CLBCD_K_NONE;
            rdy_q   <= 1'b0;
            brdy_q  <= 1'b0;
            dst_q   <= 1'b0;
            mst_q   <= 1'b0;
            ist_q   <= 1'b0;
            i16_q   <= 1'b0;
            smi_q   <= 1'b0;
            shut_q  <= 1'b0;
            rcnt_q  <= '0;
            rst_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            kind_q  <= kind_d;
            rdy_q   <= rdy_d;
            brdy_q  <= brdy_d;
            dst_q   <= dst_d;
            mst_q   <= mst_d;
            ist_q   <= ist_d;
            i16_q   <= i16_d;
            smi_q   <= smi_d;
            shut_q  <= shut_d;
            rcnt_q  <= rcnt_d;
            rst_q   <= rst_d;
        end
    end

    // Ready pins are driven only while asserted, leaving claimed cycles
    // to the claiming slave's own driver.
    assign rdy_n_o             = ~rdy_q;
    assign rdy_n_oe            = rdy_q;
    assign brdy_n_o            = ~brdy_q;
    assign brdy_n_oe           = brdy_q;
    assign dram_start          = dst_q;
    assign isa_mem_start       = mst_q;
    assign isa_io_start        = ist_q;
    assign isa_16bit_io        = i16_q;
    assign smi_event           = smi_q;
    assign processor_reset_out = rst_q;
    assign isa_reset_out       = rst_q;

endmodule : clbcd_decoder

// ### rtl/clbcd_pkg.sv
// Purpose: Shared constants and types for the local bus cycle decoder.
// Assumes: 32-bit local address, 50 MHz local bus clock.
// Notes:   Decode windows and timings are named here, never bare in logic.
package clbcd_pkg;

    localparam int          CLK_MHZ          = 50;
    localparam int          SHUT_MIN_CLKS    = 16;
    localparam int          SHUT_CNT_W       = 5;
    localparam logic [4:0]  SHUT_HOLD        = 5'(SHUT_MIN_CLKS);
    localparam logic [31:0] ISA_LIMIT        = 32'h0100_0000;
    localparam int          A31_BIT          = 31;
    localparam int          RAW_MSB          = 2;

    // Processor bus cycle definition encoding {m_io_n, d_c_n, w_r_n}.
    localparam logic [2:0]  CDEF_IACK        = 3'h0;
    localparam logic [2:0]  CDEF_SPECIAL     = 3'h1;
    localparam logic [2:0]  CDEF_IO_RD       = 3'h2;
    localparam logic [2:0]  CDEF_IO_WR       = 3'h3;

    // Special cycle byte enable codes (active low), with address bit 2.
    localparam logic [3:0]  BE_SHUTDOWN      = 4'he;
    localparam logic [3:0]  BE_FLUSH         = 4'hd;
    localparam logic [3:0]  BE_HALT          = 4'hb;
    localparam logic [3:0]  BE_WRBACK        = 4'h7;

    // Halt response selections.
    localparam logic [1:0]  HALT_RDY_ONLY    = 2'h0;
    localparam logic [1:0]  HALT_RDY_SMI     = 2'h1;

    typedef enum logic [2:0] {
        CLBCD_IDLE,
        CLBCD_DECODE,
        CLBCD_WAIT,
        CLBCD_TERM,
        CLBCD_END
    } clbcd_state_t;

    typedef enum logic [2:0] {
        CLBCD_K_NONE,
        CLBCD_K_DRAM,
        CLBCD_K_REG,
        CLBCD_K_ISA,
        CLBCD_K_SPECIAL
    } clbcd_kind_t;

endpackage : clbcd_pkg

// ### test/clbcd_properties.sv
// Purpose: Port-level properties of the local bus cycle decoder.
// Assumes: Engines report completion by one-cycle pulses.
// Notes:   Bound into every decoder instance.
`timescale 1ns/1ps
module clbcd_properties
    import clbcd_pkg::*;
#(
    parameter int SHUT_CLKS = SHUT_MIN_CLKS
)(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [1:0] halt_option,
    input wire logic       dram_xfer_done,
    input wire logic       isa_done,
    input wire logic       rdy_n_o,
    input wire logic       rdy_n_oe,
    input wire logic       brdy_n_o,
    input wire logic       brdy_n_oe,
    input wire logic       dram_start,
    input wire logic       isa_mem_start,
    input wire logic       isa_io_start,
    input wire logic       smi_event,
    input wire logic       processor_reset_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] hi_q;
    logic [7:0] hi_d;
    // Counts how long the reset output has stood high so far.
    always_comb hi_d = processor_reset_out ? hi_q + 8'h01 : 8'h00;
    always_ff @(posedge clk) hi_q <= resetn ? hi_d : 8'h00;
    rdy_low_a: assert property (rdy_n_oe |-> !rdy_n_o) else $error("rdy not low");
    rdy_pulse_a: assert property (rdy_n_oe |=> !rdy_n_oe) else $error("rdy twice");
    isa_rdy_a: assert property (isa_done |-> ##2 rdy_n_oe) else $error("no isa rdy");
    brdy_low_a: assert property (brdy_n_oe |-> !brdy_n_o) else $error("brdy not low");
    brdy_xfer_a: assert property (dram_xfer_done |=> brdy_n_oe) else $error("no brdy");
    one_term_a: assert property (!(rdy_n_oe && brdy_n_oe)) else $error("two ends");
    one_start_a: assert property (
        $onehot0({dram_start, isa_mem_start, isa_io_start}))
        else $error("two starts");
    smi_opt_a: assert property (smi_event |-> halt_option == HALT_RDY_SMI)
        else $error("smi without option");
    reset_len_a: assert property (
        $fell(processor_reset_out) |-> hi_q >= 8'(SHUT_CLKS))
        else $error("reset short");
    cover property (smi_event);
    cover property ($fell(processor_reset_out));
    cover property (brdy_n_oe ##1 !brdy_n_oe ##[1:20] brdy_n_oe);
endmodule : clbcd_properties

bind clbcd_decoder clbcd_properties #(.SHUT_CLKS(SHUT_CLKS)) u_props (.clk, .resetn,
    .halt_option, .dram_xfer_done, .isa_done, .rdy_n_o, .rdy_n_oe, .brdy_n_o, .brdy_n_oe,
    .dram_start, .isa_mem_start, .isa_io_start, .smi_event, .processor_reset_out);

// ### test/clbcd_engine_model.sv
// Purpose: Behavioural DRAM and ISA engines answering the decoder's starts.
// Assumes: lat gives the answer delay in clocks, at least one.
// Notes:   A burst is four transfers, a single cycle one.
`timescale 1ns/1ps
module clbcd_engine_model (
    input  wire logic       clk,
    input  wire logic       blast_n,
    input  wire logic [3:0] lat,
    input  wire logic       dram_start,
    input  wire logic       isa_mem_start,
    input  wire logic       isa_io_start,
    output logic            dram_xfer_done,
    output logic            dram_last_done,
    output logic            isa_done
);
    int n;
    initial {dram_xfer_done, dram_last_done, isa_done} = 3'h0;
    always @(posedge clk)
    begin
        if (isa_mem_start || isa_io_start)
        begin
            repeat (lat) @(posedge clk);
            isa_done <= 1'h1;
            @(posedge clk);
            isa_done <= 1'h0;
        end
        // Transfer pacing stands in for the programmed DRAM timing.
        if (dram_start)
            for (n = blast_n ? 4 : 1; n > 0; n--)
            begin
                repeat (lat) @(posedge clk);
                {dram_xfer_done, dram_last_done} <= {1'h1, n == 1};
                @(posedge clk);
                {dram_xfer_done, dram_last_done} <= 2'h0;
            end
    end
endmodule : clbcd_engine_model

// ### test/tb_cpu_local_bus_cycle_decoder.sv
// Purpose: Self-checking bench for the local bus cycle decoder.
// Assumes: Engines answer through the behavioural model.
// Notes:   The driver queues expected port events; the monitor drains them.
`timescale 1ns/1ps
module tb_cpu_local_bus_cycle_decoder;
    import clbcd_pkg::*;
    logic        clk, resetn, ads_n, m_io_n, d_c_n, w_r_n, blast_n, local_slave_claim_n;
    logic        boot_rom_chip_enable, dram_hit, reg_hit, dram_xfer_done, dram_last_done;
    logic        isa_done, rdy_n_o, rdy_n_oe, brdy_n_o, brdy_n_oe, dram_start;
    logic        isa_mem_start, isa_io_start, isa_16bit_io, smi_event;
    logic        processor_reset_out, isa_reset_out;
    logic [31:2] addr;
    logic [3:0]  be_n, lat;
    logic [1:0]  halt_option;
    logic [31:0] seed;
    logic [3:0]  expq[$];
    logic [3:0]  bes[4] = '{BE_WRBACK, BE_FLUSH, BE_HALT, BE_HALT};
    int          failures, cmp_count, smi_seen, rst_hi, terms, i;
    clbcd_decoder dut (.clk, .resetn, .ads_n, .addr, .be_n, .m_io_n, .d_c_n, .w_r_n,
        .blast_n, .local_slave_claim_n, .boot_rom_chip_enable, .dram_hit, .reg_hit,
        .halt_option, .dram_xfer_done, .dram_last_done, .isa_done, .rdy_n_o, .rdy_n_oe,
        .brdy_n_o, .brdy_n_oe, .dram_start, .isa_mem_start, .isa_io_start, .isa_16bit_io,
        .smi_event, .processor_reset_out, .isa_reset_out);
    clbcd_engine_model u_eng (.clk, .blast_n, .lat, .dram_start, .isa_mem_start,
        .isa_io_start, .dram_xfer_done, .dram_last_done, .isa_done);
    task automatic cmp(input logic [31:0] e, input logic [31:0] a, input string what);
        cmp_count++;
        if (e !== a)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, e, a);
        end
    endtask : cmp
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic ev(input logic [3:0] code);
        cmp(expq.size() ? expq.pop_front() : 4'h0, code, "port event");
    endtask : ev
    // Cycle info stays put from the strobe until termination, as a master must.
    task automatic run(input logic [31:2] a, input logic [3:0] be, input logic [2:0] cd,
        input logic cl, input logic dh, input logic rh, input logic [23:0] evs, input int nt);
        int w;
        @(posedge clk);
        {addr, be_n, m_io_n, d_c_n, w_r_n} <= {a, be, cd};
        {local_slave_claim_n, dram_hit, reg_hit, ads_n} <= {cl, dh, rh, 1'h0};
        for (w = 0; w < 6; w++)
            if (evs[w*4+:4] != 4'h0) expq.push_back(evs[w*4+:4]);
        terms = 0;
        for (w = 0; w < 200 && (terms < nt || (nt == 0 && w < 12)); w++) @(posedge clk);
        ads_n <= 1'h1;
        cmp(nt, terms, "terminations");
        repeat (8) @(posedge clk);
    endtask : run
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk)
        if (resetn === 1'h1)
        begin
            if (dram_start === 1'h1) ev(4'h1);
            if (isa_mem_start === 1'h1) ev(4'h2);
            if (isa_io_start === 1'h1) ev(isa_16bit_io === 1'h1 ? 4'h7 : 4'h3);
            if (brdy_n_oe === 1'h1) ev(brdy_n_o === 1'h0 ? 4'h4 : 4'hf);
            if (rdy_n_oe === 1'h1) ev(rdy_n_o === 1'h0 ? 4'h5 : 4'hf);
            terms += (rdy_n_oe === 1'h1) + (brdy_n_oe === 1'h1);
            smi_seen += (smi_event === 1'h1);
            rst_hi += (processor_reset_out === 1'h1 && isa_reset_out === 1'h1);
        end
    initial
    begin
        #200_000;
        failures++;
        close_out();
    end
    initial
    begin
        {resetn, ads_n, addr, be_n, m_io_n, d_c_n, w_r_n, blast_n} = {2'h1, 30'h0, 8'hff};
        {local_slave_claim_n, boot_rom_chip_enable, dram_hit, reg_hit} = 4'h8;
        {halt_option, lat, seed} = {2'h0, 4'h1, 32'h10d0_5bef};
        {failures, cmp_count, smi_seen, rst_hi, terms} = '0;
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        for (i = 0; i < 4; i++)
        begin
            lat <= 4'h1 + 4'($random(seed) & 3);
            boot_rom_chip_enable <= 1'($random(seed));
            blast_n <= i[0];
            run(30'($random(seed)) & 30'h3fff, 4'h0, CDEF_IO_RD | 3'(i & 1),
                1, 0, 0, 24'h53, 1);
            run(30'($random(seed)) & 30'hff, i[0] ? 4'hc : 4'he, CDEF_IO_RD,
                1, 0, 1, 24'h57, 1);
            run(ISA_LIMIT[31:2] - 30'h1, 4'h0, 3'h6 | 3'(i & 1), 1, 0, 0,
                24'h52, 1);
            // Odd passes write, and with blast_n high they burst four transfers.
            run(30'($random(seed)) & 30'hff, 4'h0, 3'h6 | 3'(i & 1), 1, 1, 0,
                i[0] ? 24'h4_4441 : 24'h41, i[0] ? 4 : 1);
            // The claiming slave answers with its own ready, so the block stays silent.
            run(30'($random(seed)) & 30'hff, 4'h0, CDEF_IO_WR, 0, 0, 0,
                24'h0, 0);
        end
        boot_rom_chip_enable <= 1'h0;
        run({1'h1, 29'($random(seed))}, 4'h0, 3'h6, 1, 0, 0, 24'h52, 1);
        for (i = 0; i < 4; i++)
        begin
            halt_option <= i == 3 ? HALT_RDY_SMI : HALT_RDY_ONLY;
            run(30'h0, bes[i], CDEF_SPECIAL, 1, 0, 0, 24'h5, 1);
        end
        cmp(1, smi_seen, "smi pulses");
        run(30'h0, BE_SHUTDOWN, CDEF_SPECIAL, 1, 0, 0, 24'h5, 1);
        repeat (30) @(posedge clk);
        cmp(1, rst_hi >= SHUT_MIN_CLKS, "reset length");
        cmp(0, expq.size(), "events left");
        close_out();
    end
endmodule : tb_cpu_local_bus_cycle_decoder
